// ### dv/esp_ctrl_model.sv
// Purpose: Bus controller side of the parallel poll.
// Assumes: Data lines have pull-ups, so released lines read high.
// Notes:   The poll follows the bench request one edge later.
`timescale 1ns/1ps
module esp_ctrl_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_poll,
  input  wire logic [7:0] i_pp_data,
  input  wire logic       i_pp_oe_n,
  output logic            o_pp_active,
  output logic [7:0]      o_lines
);
  // ----------------------------------------------------------------
  // Poll and wire level
  // ----------------------------------------------------------------
  initial o_pp_active = 1'b0;
  always @(posedge i_ref_clk) o_pp_active <= i_poll;
  assign o_lines = i_pp_oe_n ? 8'hFF : i_pp_data;
endmodule : esp_ctrl_model

// ### dv/esp_status_checker.sv
// Purpose: Port-level checks for the event status and poll logic.
// Assumes: One clock domain; sees only the ports of esp_status.
// Notes:   Lags follow the design's one-cycle answer timing.
`timescale 1ns/1ps
module esp_status_checker (
  input wire logic                i_ref_clk,
  input wire logic                i_reset_n,
  input wire logic                i_clk_en,
  input wire logic                i_query,
  input wire esp_pkg::esp_query_t i_query_sel,
  input wire logic                i_err_pop,
  input wire logic                i_pp_active,
  input wire logic [7:0]          o_query_data,
  input wire logic                o_query_valid,
  input wire logic                o_err_valid,
  input wire logic [7:0]          o_serial_poll,
  input wire logic                o_srq,
  input wire logic [7:0]          o_pp_data,
  input wire logic                o_pp_oe_n
);
  import esp_pkg::*;
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  a_query_answer:
    assert property (i_clk_en && i_query |=> o_query_valid)
    else $error("query not answered");
  a_answer_cause:
    assert property (o_query_valid && $past(i_clk_en) |-> $past(i_query))
    else $error("answer without query");
  a_pop_answer:
    assert property (i_clk_en && i_err_pop |=> o_err_valid)
    else $error("next error not answered");
  a_bit1_clear:
    assert property (i_clk_en && i_query && i_query_sel == ESP_Q_LATCH
      |=> !o_query_data[ESP_EV_UNUS])
    else $error("unused event bit set");
  a_mss_srq:
    assert property ($rose(o_srq) |-> ##[0:2] o_serial_poll[ESP_SB_MSS])
    else $error("request without summary bit");
  a_sb_unused:
    assert property (o_serial_poll[1:0] == 2'h0 && !o_serial_poll[3]
      && !o_serial_poll[7])
    else $error("unused status bit set");
  a_poll_idle:
    assert property (i_clk_en && !i_pp_active |=> o_pp_oe_n)
    else $error("poll line driven outside poll");
  a_one_line:
    assert property (!o_pp_oe_n |-> $onehot0(o_pp_data))
    else $error("more than one poll line driven");
  a_srq_summary:
    assert property (o_srq == o_serial_poll[ESP_SB_MSS])
    else $error("request and summary bit differ");
  c_srq_seen: cover property ($rose(o_srq));
  c_poll_drv: cover property (!o_pp_oe_n);
  c_err_pop: cover property (o_err_valid);
endmodule : esp_status_checker

bind esp_status esp_status_checker i_esp_status_checker (
  .i_ref_clk, .i_reset_n, .i_clk_en, .i_query, .i_query_sel, .i_err_pop,
  .i_pp_active, .o_query_data, .o_query_valid, .o_err_valid,
  .o_serial_poll, .o_srq, .o_pp_data, .o_pp_oe_n
);

// ### dv/esp_status_tb.sv
// Purpose: Self-checking bench for the event status and poll logic.
// Assumes: Inputs change at the falling edge; queue depth cut to four.
// Notes:   A short queue lets the full case be reached in a few cycles.
`timescale 1ns/1ps
module esp_status_tb;
  import esp_pkg::*;
  // ----------------------------------------------------------------
  // Signals, helpers and checks
  // ----------------------------------------------------------------
  logic        i_ref_clk, i_reset_n, i_clk_en, i_opc_cmd, i_all_done;
  logic        i_read_no_query, i_unread_resp, i_dev_err, i_exec_err;
  logic        i_cmd_err, i_local_key, i_remote, i_power_on, i_msg_avail;
  logic        i_clear_status, i_wr_enable, i_wr_srq_en, i_wr_pp_en;
  logic        i_pp_config, i_pp_invert, i_pp_unconfig, i_query, i_err_pop;
  logic        i_pp_active, poll, o_query_valid, o_err_valid, o_srq;
  logic        o_pp_oe_n;
  logic [15:0] code, o_err_code;
  logic [7:0]  i_wr_data, o_query_data, o_serial_poll, o_pp_data, lines;
  logic [2:0]  i_pp_line;
  logic [31:0] seed;
  esp_query_t  i_query_sel;
  int          err_total, check_count;
  localparam logic [7:0]  EVB [5] = '{8'h01, 8'h04, 8'h04, 8'h40, 8'h80};
  localparam logic [15:0] CLO [3] = '{ESP_DDE_LO, ESP_EXE_LO, ESP_CME_LO};
  localparam esp_query_t  RB [3] = '{ESP_Q_ENABLE, ESP_Q_SRQ_EN, ESP_Q_PP_EN};

  esp_status #(.DEPTH(4)) i_esp_status (
    .i_ref_clk, .i_reset_n, .i_clk_en, .i_opc_cmd, .i_all_done,
    .i_read_no_query, .i_unread_resp, .i_dev_err, .i_dev_err_code(code),
    .i_exec_err, .i_exec_err_code(code), .i_cmd_err, .i_cmd_err_code(code),
    .i_local_key, .i_remote, .i_power_on, .i_msg_avail, .i_clear_status,
    .i_wr_enable, .i_wr_srq_en, .i_wr_pp_en, .i_wr_data, .i_pp_config,
    .i_pp_line, .i_pp_invert, .i_pp_unconfig, .i_query, .i_query_sel,
    .i_err_pop, .i_pp_active, .o_query_data, .o_query_valid, .o_err_code,
    .o_err_valid, .o_serial_poll, .o_srq, .o_pp_data, .o_pp_oe_n);
  esp_ctrl_model i_esp_ctrl_model (.i_ref_clk, .i_poll(poll),
    .i_pp_data(o_pp_data), .i_pp_oe_n(o_pp_oe_n),
    .o_pp_active(i_pp_active), .o_lines(lines));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Bit 6 of the service enable never takes part in the summary.
  function automatic logic [7:0] sb_f(input logic [7:0] b,
                                      input logic [7:0] e);
    return b | {1'b0, |(b & e & 8'hBF), 6'h00};
  endfunction : sb_f
  task automatic chk(input string nm, input logic [15:0] e, s);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge i_ref_clk);
    {i_opc_cmd, i_read_no_query, i_unread_resp, i_dev_err, i_exec_err,
     i_cmd_err, i_local_key, i_power_on, i_clear_status, i_wr_enable,
     i_wr_srq_en, i_wr_pp_en, i_pp_config, i_pp_unconfig, i_query,
     i_err_pop} = '0;
  endtask : step
  task automatic qry(input esp_query_t s, input logic [7:0] e);
    i_query = 1'b1;
    i_query_sel = s;
    step(1);
    chk("query_valid", 16'h0001, {15'h0000, o_query_valid});
    chk(s.name(), {8'h00, e}, {8'h00, o_query_data});
  endtask : qry
  task automatic pop(input logic [15:0] e);
    i_err_pop = 1'b1;
    step(1);
    chk("err_code", e, o_err_code);
  endtask : pop
  task automatic wr(input int j, input logic [7:0] d);
    {i_wr_enable, i_wr_srq_en, i_wr_pp_en} = 3'h4 >> j;
    i_wr_data = d;
    step(1);
  endtask : wr
  task automatic errs(input int k, input logic [15:0] c);
    {i_dev_err, i_exec_err, i_cmd_err} = 3'h4 >> k;
    code = c;
    step(1);
  endtask : errs
  task automatic sbchk(input logic [7:0] b, input logic [7:0] en);
    logic [7:0] e;
    e = sb_f(b, en);
    step(3);
    chk("serial_poll", {8'h00, e}, {8'h00, o_serial_poll});
    chk("srq", {15'h0000, e[6]}, {15'h0000, o_srq});
    qry(ESP_Q_STATUS, e);
  endtask : sbchk
  task automatic end_sim();
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    repeat (5000) @(posedge i_ref_clk);
    err_total++;
    end_sim();
  end
  initial
  begin
    {i_reset_n, i_msg_avail, i_pp_invert, i_pp_line, i_wr_data, poll} = '0;
    {i_clk_en, i_all_done, i_remote} = 3'h7;
    {code, err_total, check_count} = '0;
    i_query_sel = ESP_Q_LATCH;
    seed = 32'h00018471;
    step(0);
    repeat (8) @(posedge i_ref_clk);
    step(1);
    i_reset_n = 1'b1;
    step(1);
    qry(ESP_Q_LATCH, ESP_LATCH_RST);
    qry(ESP_Q_LATCH, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      {i_opc_cmd, i_read_no_query, i_unread_resp, i_local_key,
       i_power_on} = 5'h10 >> k;
      step(4);
      qry(ESP_Q_LATCH, EVB[k]);
    end
    i_remote = 1'b0;
    step(1);
    i_local_key = 1'b1;
    step(1);
    i_remote = 1'b1;
    qry(ESP_Q_LATCH, 8'h00);
    i_all_done = 1'b0;
    i_opc_cmd = 1'b1;
    step(1);
    qry(ESP_Q_LATCH, 8'h00);
    i_all_done = 1'b1;
    step(2);
    qry(ESP_Q_LATCH, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      errs(k, CLO[k] + 16'(xs() % 100));
      qry(ESP_Q_LATCH, 8'h08 << k);
      pop(code);
    end
    pop(ESP_NO_ERROR);
    for (int k = 0; k < 5; k++)
      errs(0, ESP_DDE_LO + 16'(k));
    for (int k = 0; k < 5; k++)
      pop(k < 4 ? ESP_DDE_LO + 16'(k) : ESP_NO_ERROR);
    qry(ESP_Q_LATCH, 8'h08);
    i_cmd_err = 1'b1;
    qry(ESP_Q_LATCH, 8'h00);
    qry(ESP_Q_LATCH, 8'h20);
    errs(0, ESP_DDE_LO);
    i_clear_status = 1'b1;
    step(1);
    pop(ESP_NO_ERROR);
    qry(ESP_Q_LATCH, 8'h00);
    i_clk_en = 1'b0;
    errs(2, ESP_CME_LO);
    i_clk_en = 1'b1;
    qry(ESP_Q_LATCH, 8'h00);
    for (int j = 0; j < 3; j++)
    begin
      wr(j, 8'(xs()));
      qry(RB[j], i_wr_data);
    end
    wr(0, 8'h01);
    wr(1, 8'h20);
    i_opc_cmd = 1'b1;
    step(1);
    sbchk(8'h20, 8'h20);
    qry(ESP_Q_LATCH, 8'h01);
    sbchk(8'h00, 8'h20);
    wr(1, 8'h04);
    errs(1, ESP_EXE_LO);
    sbchk(8'h04, 8'h04);
    pop(ESP_EXE_LO);
    qry(ESP_Q_LATCH, 8'h10);
    i_msg_avail = 1'b1;
    wr(1, 8'h40);
    sbchk(8'h10, 8'h40);
    wr(1, 8'h10);
    sbchk(8'h10, 8'h10);
    wr(2, 8'h10);
    qry(ESP_Q_IST, 8'h01);
    for (int v = 0; v < 2; v++)
    begin
      i_pp_config = 1'b1;
      i_pp_line = 3'(xs());
      i_pp_invert = v[0];
      step(1);
      poll = 1'b1;
      step(4);
      chk("pp_oe_n", 16'h0000, {15'h0000, o_pp_oe_n});
      chk("pp_bit", {15'h0, !v[0]}, {15'h0, lines[i_pp_line]});
      poll = 1'b0;
      step(2);
    end
    i_pp_unconfig = 1'b1;
    step(1);
    poll = 1'b1;
    step(4);
    chk("pp_oe_n", 16'h0001, {15'h0000, o_pp_oe_n});
    poll = 1'b0;
    step(2);
    wr(0, 8'hFF);
    wr(1, 8'hFF);
    i_power_on = 1'b1;
    step(1);
    sbchk(8'h30, 8'hFF);
    end_sim();
  end
endmodule : esp_status_tb

// ### rtl/esp_pkg.sv
// Purpose: Shared constants for the event status and poll logic.
// Assumes: One 20 MHz clock; registers reached by decoded command strobes.
// Notes:   Error codes are unsigned 16-bit values as carried by the error queue.
package esp_pkg;

  // ----------------------------------------------------------------
  // Event register bit positions
  // ----------------------------------------------------------------
  localparam int ESP_EV_OPC  = 0;
  localparam int ESP_EV_UNUS = 1;
  localparam int ESP_EV_QYE  = 2;
  localparam int ESP_EV_DDE  = 3;
  localparam int ESP_EV_EXE  = 4;
  localparam int ESP_EV_CME  = 5;
  localparam int ESP_EV_URQ  = 6;
  localparam int ESP_EV_PON  = 7;

  // ----------------------------------------------------------------
  // Status byte bit positions
  // ----------------------------------------------------------------
  localparam int ESP_SB_EAV = 2;
  localparam int ESP_SB_MAV = 4;
  localparam int ESP_SB_ESB = 5;
  localparam int ESP_SB_MSS = 6;

  // ----------------------------------------------------------------
  // Reset values and error code ranges
  // ----------------------------------------------------------------
  localparam logic [7:0]  ESP_LATCH_RST  = 8'h80;
  localparam logic [7:0]  ESP_ENABLE_RST = 8'h00;
  localparam logic [15:0] ESP_NO_ERROR   = 16'h0000;
  localparam logic [15:0] ESP_DDE_LO     = 16'h012C;
  localparam logic [15:0] ESP_DDE_HI     = 16'h018F;
  localparam logic [15:0] ESP_EXE_LO     = 16'h00C8;
  localparam logic [15:0] ESP_EXE_HI     = 16'h012C;
  localparam logic [15:0] ESP_CME_LO     = 16'h0064;
  localparam logic [15:0] ESP_CME_HI     = 16'h00C8;
  localparam int          ESP_QUEUE_DEPTH = 16;

  // ----------------------------------------------------------------
  // Query selector
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ESP_Q_LATCH,
    ESP_Q_ENABLE,
    ESP_Q_STATUS,
    ESP_Q_SRQ_EN,
    ESP_Q_PP_EN,
    ESP_Q_IST
  } esp_query_t;

endpackage : esp_pkg

// ### rtl/esp_status.sv
// Purpose: Event latch, status byte, service request, polls and error queue.
// Assumes: Commands arrive as one-cycle strobes already decoded by the parser.
// Notes:   Query answers are the register bit pattern in binary; the
//          formatter turns them into decimal text.
//
// Overview of operation
// RULE1 - Operation complete bit sets on opc once prior commands finished.
// RULE2 - Query error bit sets on read without query or unread response.
// RULE3 - Device error sets bit 3 and queues a code 300..399 or positive.
// RULE4 - Execution error sets bit 4 and queues a code 200..300.
// RULE5 - Command error sets bit 5 and queues a code 100..200.
// RULE6 - Local key switching to manual operation sets user request bit 6.
// RULE7 - Power on sets bit 7; bit 1 is never set.
// RULE8 - Event enable register is writable and readable; latch is readable.
// RULE9 - Service request whenever status bits 2, 4 or 5 are set and enabled.
// RULE10 - Serial poll returns the same status byte as the status query.
// RULE11 - Parallel poll drives one bit on the allocated data line.
// RULE12 - Poll result is OR of enable AND status byte, optionally inverted.
// RULE13 - Individual status flag is readable by query without a poll.
// RULE14 - Configure command stores data line and inversion before polling.
// RULE15 - Each status query returns the queried register's bit pattern.
// RULE16 - Errors append to the queue; reads pop; empty queue returns code 0.
// RULE17 - Controller should set all service and event enable bits to one.
// RULE18 - Controller sets service and poll enables equal for polling.
// RULE19 - Controller should read the error queue after each service request.
// RULE20 - Status bit 5 is set when any enabled event latch bit is set.
// RULE21 - Enabled status bit rising raises a request; enable bit 6 ignored.
// RULE22 - Reading the event latch returns its contents then clears it.
// RULE23 - Status bit 6 is set whenever a service request is asserted.
// RULE24 - Event latch bits stay set until read or cleared.
// RULE25 - An event arriving with a clearing read remains set.
`timescale 1ns/1ps

module esp_status #(
  parameter int DEPTH = esp_pkg::ESP_QUEUE_DEPTH
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_reset_n,
  input  wire logic                i_clk_en,
  input  wire logic                i_opc_cmd,
  input  wire logic                i_all_done,
  input  wire logic                i_read_no_query,
  input  wire logic                i_unread_resp,
  input  wire logic                i_dev_err,
  input  wire logic [15:0]         i_dev_err_code,
  input  wire logic                i_exec_err,
  input  wire logic [15:0]         i_exec_err_code,
  input  wire logic                i_cmd_err,
  input  wire logic [15:0]         i_cmd_err_code,
  input  wire logic                i_local_key,
  input  wire logic                i_remote,
  input  wire logic                i_power_on,
  input  wire logic                i_msg_avail,
  input  wire logic                i_clear_status,
  input  wire logic                i_wr_enable,
  input  wire logic                i_wr_srq_en,
  input  wire logic                i_wr_pp_en,
  input  wire logic [7:0]          i_wr_data,
  input  wire logic                i_pp_config,
  input  wire logic [2:0]          i_pp_line,
  input  wire logic                i_pp_invert,
  input  wire logic                i_pp_unconfig,
  input  wire logic                i_query,
  input  wire esp_pkg::esp_query_t i_query_sel,
  input  wire logic                i_err_pop,
  input  wire logic                i_pp_active,
  output logic [7:0]               o_query_data,
  output logic                     o_query_valid,
  output logic [15:0]              o_err_code,
  output logic                     o_err_valid,
  output logic [7:0]               o_serial_poll,
  output logic                     o_srq,
  output logic [7:0]               o_pp_data,
  output logic                     o_pp_oe_n
);
  import esp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("DEPTH must be a power of two of at least 2");
  end

  // ----------------------------------------------------------------
  // Event latch and enable registers
  // ----------------------------------------------------------------
  logic [7:0] latch_r, latch_nxt;
  logic [7:0] enable_r, enable_nxt;
  logic [7:0] srq_en_r, srq_en_nxt;
  logic [7:0] pp_en_r, pp_en_nxt;
  logic       opc_wait_r, opc_wait_nxt;
  logic       remote_r, remote_nxt;
  logic [7:0] ev_set;
  logic       latch_rd;

  assign latch_rd = i_query && (i_query_sel == ESP_Q_LATCH);

  always_comb
  begin
    ev_set         = 8'h00;
    opc_wait_nxt   = opc_wait_r;
    remote_nxt     = i_remote;
    // The opc strobe may find older commands still running, so wait.
    if (i_opc_cmd && !i_all_done)
      opc_wait_nxt = 1'b1;
    if ((i_opc_cmd || opc_wait_r) && i_all_done)
    begin
      ev_set[ESP_EV_OPC] = 1'b1;                       // see RULE1
      opc_wait_nxt       = 1'b0;
    end
    ev_set[ESP_EV_QYE] = i_read_no_query | i_unread_resp; // see RULE2
    ev_set[ESP_EV_DDE] = i_dev_err;                    // see RULE3
    ev_set[ESP_EV_EXE] = i_exec_err;                   // see RULE4
    ev_set[ESP_EV_CME] = i_cmd_err;                    // see RULE5
    // The key counts only if the block was under remote control a cycle ago.
    ev_set[ESP_EV_URQ] = i_local_key && remote_r;      // see RULE6
    ev_set[ESP_EV_PON] = i_power_on;                   // see RULE7
    ev_set[ESP_EV_UNUS] = 1'b0;                        // see RULE7
    latch_nxt = latch_r;
    if (latch_rd || i_clear_status)
      latch_nxt = 8'h00;                               // see RULE22
    // The set follows the clear, so an event met by a clearing read is kept.
    latch_nxt = latch_nxt | ev_set;                    // see RULE24, RULE25
    enable_nxt = i_wr_enable ? i_wr_data : enable_r;   // see RULE8
    srq_en_nxt = i_wr_srq_en ? i_wr_data : srq_en_r;
    pp_en_nxt  = i_wr_pp_en ? i_wr_data : pp_en_r;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      latch_r    <= ESP_LATCH_RST;
      enable_r   <= ESP_ENABLE_RST;
      srq_en_r   <= ESP_ENABLE_RST;
      pp_en_r    <= ESP_ENABLE_RST;
      opc_wait_r <= 1'b0;
      remote_r   <= 1'b0;
    end
    else if (i_clk_en)
    begin
      latch_r    <= latch_nxt;
      enable_r   <= enable_nxt;
      srq_en_r   <= srq_en_nxt;
      pp_en_r    <= pp_en_nxt;
      opc_wait_r <= opc_wait_nxt;
      remote_r   <= remote_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Error queue
  // ----------------------------------------------------------------
  // The memory has no reset; only the pointers say which words are valid.
  logic [15:0] queue_mem [DEPTH];
  logic [AW:0] wr_ptr_r, wr_ptr_nxt;
  logic [AW:0] rd_ptr_r, rd_ptr_nxt;
  logic [15:0] push_code;
  logic        push, q_empty, q_full, pop;

  assign q_empty = (wr_ptr_r == rd_ptr_r);
  assign q_full  = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && !q_empty;
  assign pop     = i_err_pop && !q_empty;

  always_comb
  begin
    push      = i_dev_err | i_exec_err | i_cmd_err;    // see RULE16
    // One entry per cycle; the most serious class wins a collision.
    if (i_dev_err)
      push_code = i_dev_err_code;                      // see RULE3
    else if (i_exec_err)
      push_code = i_exec_err_code;                     // see RULE4
    else
      push_code = i_cmd_err_code;                      // see RULE5
    // A full queue keeps its oldest entries; new errors are dropped.
    wr_ptr_nxt = (push && !q_full) ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    if (i_clear_status)
      rd_ptr_nxt = wr_ptr_nxt;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_clk_en && push && !q_full)
      queue_mem[wr_ptr_r[AW-1:0]] <= push_code;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else if (i_clk_en)
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status byte, service request and parallel poll
  // ----------------------------------------------------------------
  logic [7:0] status;
  logic       rqs, ist;
  logic [7:0] srq_mask;
  logic [7:0] sb_prev_r, sb_prev_nxt;
  logic       srq_r, srq_nxt;
  logic [2:0] pp_line_r, pp_line_nxt;
  logic       pp_inv_r, pp_inv_nxt;
  logic       pp_cfg_r, pp_cfg_nxt;

  always_comb
  begin
    status             = 8'h00;
    status[ESP_SB_EAV] = !q_empty;
    status[ESP_SB_MAV] = i_msg_avail;
    status[ESP_SB_ESB] = |(latch_r & enable_r);        // see RULE20
    srq_mask           = srq_en_r;
    // Bit 6 never masks a request, since it is the summary itself.
    srq_mask[ESP_SB_MSS] = 1'b0;                       // see RULE21
    rqs                = |(status & srq_mask);         // see RULE9
    status[ESP_SB_MSS] = rqs;                          // see RULE23
    ist                = (|(status & pp_en_r)) ^ pp_inv_r; // see RULE12
    // The masked byte is kept, so that enabling a bit that is already set
    // counts as a rise and raises the request as well.
    sb_prev_nxt        = status & srq_mask;
    srq_nxt            = srq_r;
    if (|(status & srq_mask & ~sb_prev_r))
      srq_nxt = 1'b1;                                  // see RULE21
    if (!rqs)
      srq_nxt = 1'b0;
    pp_line_nxt = i_pp_config ? i_pp_line : pp_line_r; // see RULE14
    pp_inv_nxt  = i_pp_config ? i_pp_invert : pp_inv_r;
    // A configure in the same cycle as an unconfigure wins.
    pp_cfg_nxt  = pp_cfg_r;
    if (i_pp_config)
      pp_cfg_nxt = 1'b1;
    else if (i_pp_unconfig)
      pp_cfg_nxt = 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sb_prev_r <= 8'h00;
      srq_r     <= 1'b0;
      pp_line_r <= 3'h0;
      pp_inv_r  <= 1'b0;
      pp_cfg_r  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      sb_prev_r <= sb_prev_nxt;
      srq_r     <= srq_nxt;
      pp_line_r <= pp_line_nxt;
      pp_inv_r  <= pp_inv_nxt;
      pp_cfg_r  <= pp_cfg_nxt;
    end
  end

  assign o_srq = srq_r;

  // ----------------------------------------------------------------
  // Query answers and poll outputs
  // ----------------------------------------------------------------
  logic [7:0]  qdata_r, qdata_nxt;
  logic        qvalid_r, qvalid_nxt;
  logic [15:0] ecode_r, ecode_nxt;
  logic        evalid_r, evalid_nxt;
  logic [7:0]  spoll_r, spoll_nxt;
  logic [7:0]  ppd_r, ppd_nxt;
  logic        ppoe_n_r, ppoe_n_nxt;

  always_comb
  begin
    // The answer is taken before the edge, so a clearing read sees the old
    // contents.
    qvalid_nxt = i_query;
    qdata_nxt  = qdata_r;
    if (i_query)
    begin
      case (i_query_sel)                               // see RULE15
        ESP_Q_LATCH:  qdata_nxt = latch_r;             // see RULE8, RULE22
        ESP_Q_ENABLE: qdata_nxt = enable_r;            // see RULE8
        ESP_Q_STATUS: qdata_nxt = status;
        ESP_Q_SRQ_EN: qdata_nxt = srq_en_r;
        ESP_Q_PP_EN:  qdata_nxt = pp_en_r;
        ESP_Q_IST:    qdata_nxt = {7'h00, ist};        // see RULE13
        default:      qdata_nxt = 8'h00;
      endcase
    end
    evalid_nxt = i_err_pop;
    ecode_nxt  = ecode_r;
    // An empty queue answers with the no-error code, never with stale data.
    if (i_err_pop)
      ecode_nxt = q_empty ? ESP_NO_ERROR
                          : queue_mem[rd_ptr_r[AW-1:0]]; // see RULE16
    spoll_nxt  = status;                               // see RULE10
    // Only a configured device may answer, or lines would be corrupted.
    ppoe_n_nxt = !(i_pp_active && pp_cfg_r);           // see RULE11
    ppd_nxt    = 8'h00;
    ppd_nxt[pp_line_r] = ist;                          // see RULE11
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      qdata_r  <= 8'h00;
      qvalid_r <= 1'b0;
      ecode_r  <= 16'h0000;
      evalid_r <= 1'b0;
      spoll_r  <= 8'h00;
      ppd_r    <= 8'h00;
      ppoe_n_r <= 1'b1;
    end
    else if (i_clk_en)
    begin
      qdata_r  <= qdata_nxt;
      qvalid_r <= qvalid_nxt;
      ecode_r  <= ecode_nxt;
      evalid_r <= evalid_nxt;
      spoll_r  <= spoll_nxt;
      ppd_r    <= ppd_nxt;
      ppoe_n_r <= ppoe_n_nxt;
    end
  end

  assign o_query_data  = qdata_r;
  assign o_query_valid = qvalid_r;
  assign o_err_code    = ecode_r;
  assign o_err_valid   = evalid_r;
  assign o_serial_poll = spoll_r;
  assign o_pp_data     = ppd_r;
  assign o_pp_oe_n     = ppoe_n_r;

endmodule : esp_status
